// file: sepc_pkg.sv
// Shared constants, command codes and state encoding for the serial memory pin control block
// ============================================================================
// Overview of operation
// - Select low selects; high means standby
// - Started programming cycle finishes despite deselect
// - Deselected device releases serial output
// - Only select rise after valid write starts cycle
// - Internal write finishes within five milliseconds
// - Read data changes after shift clock falls
// - Input bits captured on shift clock rise
// - Protect pin plus enable bit blocks status writes
// - Protect pin high lets everything work
// - Enable bit clear makes protect pin ignored
// - Protect pin falling never aborts running cycle
// - Pause entry keeps state, clock-low or next fall; this design pauses at once at either clock level
// - Paused device ignores input and shift clock
// - Resume at once if clock low, else next fall; this design resumes at once at either clock level
// - Pause floats serial output immediately, release drives
// - All fields travel most significant bit first
// ============================================================================
`default_nettype none

package sepc_pkg;

  // ==========================================================================
  // Geometry
  localparam int unsigned ADDR_W = 15;            // Byte address width of the array
  localparam int unsigned PAGE_W = 6;             // Byte offset width inside one page

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_READ  = 8'h03;       // Read array
  localparam logic [7:0] CMD_WRITE = 8'h02;       // Write array page
  localparam logic [7:0] CMD_WRDI  = 8'h04;       // Clear write enable latch
  localparam logic [7:0] CMD_WREN  = 8'h06;       // Set write enable latch
  localparam logic [7:0] CMD_RDSR  = 8'h05;       // Read status
  localparam logic [7:0] CMD_WRSR  = 8'h01;       // Write status

  // ==========================================================================
  // Status field positions
  localparam int unsigned ST_WIP  = 0;            // Write in progress
  localparam int unsigned ST_WEL  = 1;            // Write enable latch
  localparam int unsigned ST_BP0  = 2;            // Block protect, low bit
  localparam int unsigned ST_BP1  = 3;            // Block protect, high bit
  localparam int unsigned ST_PROTECT_PIN_ENABLE_BIT = 7;            // protect_pin_enable_bit

  // ==========================================================================
  // Reset values
  localparam logic       WEL_RST  = 1'b0;         // Latch clear at power-up
  localparam logic       PROTECT_PIN_ENABLE_BIT_RST = 1'b0;         // Protect pin ignored at start
  localparam logic [1:0] BP_RST   = 2'h0;         // No block protected at start

  // ==========================================================================
  // Frame byte positions (full bytes received)
  localparam logic [2:0] BYTE_CMD  = 3'h0;        // Command byte
  localparam logic [2:0] BYTE_AHI  = 3'h1;        // Address high or status data
  localparam logic [2:0] BYTE_ALO  = 3'h2;        // Address low
  localparam logic [2:0] BYTE_DATA = 3'h3;        // First data byte
  localparam logic [2:0] LEN_CTRL  = 3'h1;        // Latch commands are one byte
  localparam logic [2:0] LEN_WRSR  = 3'h2;        // Status write is two bytes
  localparam logic [2:0] LEN_WRMIN = 3'h4;        // Write needs one data byte

  // ==========================================================================
  // Timing
  localparam int unsigned    TWC_MS        = 5;     // Longest internal write time
  localparam int unsigned    CLK_PERIOD_PS = 5000;  // System clock period
  localparam longint unsigned TWC_CYCLES_L =
    (64'(TWC_MS) * 64'd1_000_000_000) / 64'(CLK_PERIOD_PS);
  localparam int unsigned    TWC_CYCLES    = 32'(TWC_CYCLES_L); // Rounded down
  localparam int unsigned    SYNC_LAG      = 3;     // Select edge to commit cycles

  // ==========================================================================
  // Internal write engine states
  typedef enum logic [2:0] {
    SEPC_IDLE = 3'b001,                           // No cycle running
    SEPC_COPY = 3'b010,                           // Page buffer to array
    SEPC_WAIT = 3'b100                            // Remaining cycle time
  } sepc_state_t;

endpackage : sepc_pkg

`default_nettype wire

// file: sepc_ram.sv
// Two-clock byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module sepc_ram #(
  parameter int unsigned W  = 8,                  // Word width
  parameter int unsigned AW = 6                   // Address width
) (
  input  wire logic          wr_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic          rd_clk,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output var  logic [W-1:0]  rd_data_q
);

  // ==========================================================================
  // Storage
  logic [W-1:0] mem [2**AW];                      // Content is not reset

  // Write port on its own clock
  always_ff @(posedge wr_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read port holds its word while disabled
  always_ff @(posedge rd_clk) begin
    if (rd_en) begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule : sepc_ram

`default_nettype wire

// file: sepc_core.sv
// Serial memory slave: link shifting, pause, protect gating and self-timed write
`timescale 1ns/1ps
`default_nettype none

module sepc_core #(
  parameter int unsigned TWC_CYCLES = sepc_pkg::TWC_CYCLES, // Write cycle length
  parameter int unsigned ADDR_W     = sepc_pkg::ADDR_W,     // Array address width
  parameter int unsigned PAGE_W     = sepc_pkg::PAGE_W      // Page offset width
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic shift_clock,
  input  wire logic device_select_n,
  input  wire logic serial_in,
  output var  logic serial_out,
  output var  logic serial_out_oe,
  input  wire logic protect_pin_n,
  input  wire logic pause_input_n,
  output var  logic write_busy,
  output var  logic standby
);

  localparam int unsigned PAGES = 2**PAGE_W;     // Bytes in one page

  // ==========================================================================
  // Elaboration checks
  generate
    if (ADDR_W > 16 || ADDR_W < PAGE_W + 2 || PAGE_W < 1) begin : g_bad_geom
      $error("sepc_core: address or page width not supported");
    end
    if (TWC_CYCLES < PAGES + sepc_pkg::SYNC_LAG + 4) begin : g_bad_twc
      $error("sepc_core: write cycle shorter than page copy");
    end
  endgenerate

  // ==========================================================================
  // Link domain state (shift_clock)
  logic              fresh_q;                     // No active edge yet this frame
  logic [2:0]        bit_q;                       // Bits of current byte received
  logic [2:0]        byte_q;                      // Full bytes received, saturating
  logic [6:0]        shift_q;                     // Partial input byte
  logic [7:0]        cmd_q;                       // Command of this frame
  logic [7:0]        arg_q;                       // Second byte of the frame
  logic [ADDR_W-1:0] addr_q;                      // Start address of the frame
  logic [ADDR_W-1:0] rptr_q;                      // Next array byte to fetch
  logic [PAGE_W-1:0] wofs_q;                      // Data bytes taken for the page
  logic [PAGES-1:0]  mask_q;                      // Page bytes written this frame
  logic [7:0]        stat_s1_q;                   // Status sync, first stage
  logic [7:0]        stat_s2_q;                   // Status sync, second stage
  logic [6:0]        osr_q;                       // Remaining output bits
  logic              so_q;                        // Output bit
  logic              drive_q;                     // Output phase reached

  // Link domain decoding
  logic [7:0]        rx_byte;                     // Byte completing on this edge
  logic              byte_done;                   // Eighth bit arrives on this edge
  logic [15:0]       addr16;                      // Address bytes joined
  logic [ADDR_W-1:0] addr_full;                   // Address with unused top dropped
  logic              pb_we;                       // Page buffer write strobe
  logic [PAGE_W-1:0] pb_waddr;                    // Page buffer slot, wraps in page
  logic [ADDR_W-1:0] ar_raddr;                    // Array read address
  logic [7:0]        ar_rdata;                    // Array read data
  logic              load_rd;                     // Load array byte for output
  logic              load_st;                     // Load status byte for output

  // ==========================================================================
  // System domain state (clock)
  logic                  cs_s1_q, cs_s2_q, cs_s3_q; // Select sync and edge history
  logic                  wp_s1_q, wp_s2_q;        // Protect pin sync
  sepc_pkg::sepc_state_t state_q;                 // Write engine state
  logic [31:0]           tmr_q;                   // Cycles since commit
  logic [PAGE_W:0]       idx_q;                   // Copy slot being read
  logic [PAGE_W-1:0]     pidx_q;                  // Copy slot being written
  logic                  pv_q;                    // pidx_q holds a live slot
  logic [PAGES-1:0]      mask_l_q;                // Frame mask taken at commit
  logic [ADDR_W-1:0]     base_q;                  // Page address taken at commit
  logic                  is_stat_q;               // Cycle writes the status bits
  logic [7:0]            nstat_q;                 // Status byte to program
  logic                  wel_q, wip_q, protect_pin_enable_bit_q;    // Status bits
  logic [1:0]            bp_q;                    // Block protect bits
  logic                  standby_q;               // Deselected and idle
  logic [7:0]            status_w;                // Status byte as read out
  logic [7:0]            pb_rdata;                // Page buffer read data

  // System domain decoding
  logic commit, whole, wren_ok, wrdi_ok, write_ok, wrsr_ok, done, ar_we;
  logic [ADDR_W-1:0] ar_waddr;                    // Array write address

  // ==========================================================================
  // Block protection decode: top quarter, top half or all
  function automatic logic blk_prot(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
    case (bp)
      2'h0:    blk_prot = 1'b0;
      2'h1:    blk_prot = &a[ADDR_W-1 -: 2];
      2'h2:    blk_prot = a[ADDR_W-1];
      default: blk_prot = 1'b1;
    endcase
  endfunction : blk_prot

  // ==========================================================================
  // Link input decoding
  assign rx_byte   = {shift_q, serial_in};
  assign byte_done = ~fresh_q && (bit_q == 3'h7);
  assign addr16    = {arg_q, rx_byte};
  assign addr_full = addr16[ADDR_W-1:0];
  assign pb_we     = pause_input_n && byte_done && (byte_q >= sepc_pkg::BYTE_DATA)
                     && (cmd_q == sepc_pkg::CMD_WRITE) && ~stat_s2_q[sepc_pkg::ST_WIP];
  assign pb_waddr  = addr_q[PAGE_W-1:0] + wofs_q; // Page wraps, never spills over
  assign ar_raddr  = (byte_done && byte_q == sepc_pkg::BYTE_ALO) ? addr_full : rptr_q;
  assign load_rd   = (bit_q == 3'h0) && (byte_q >= sepc_pkg::BYTE_DATA)
                     && (cmd_q == sepc_pkg::CMD_READ);
  assign load_st   = (bit_q == 3'h0) && (byte_q >= sepc_pkg::BYTE_AHI)
                     && (cmd_q == sepc_pkg::CMD_RDSR);

  // Frame start marker, set while deselected so the link side never uses stale counts
  always_ff @(posedge shift_clock or posedge device_select_n) begin
    if (device_select_n) begin
      fresh_q <= 1'b1;
    end else if (pause_input_n) begin
      fresh_q <= 1'b0;
    end
  end

  // Bit capture on rising edges; a paused edge changes nothing
  always_ff @(posedge shift_clock) begin
    if (pause_input_n) begin
      if (fresh_q) begin
        bit_q   <= 3'h1;
        byte_q  <= 3'h0;
        shift_q <= {6'h00, serial_in};
      end else begin
        bit_q   <= bit_q + 3'h1;
        shift_q <= rx_byte[6:0];
        if (byte_done && byte_q != 3'h7) begin
          byte_q <= byte_q + 3'h1;
        end
      end
    end
  end

  // Frame fields kept until the next frame so the engine can read them
  always_ff @(posedge shift_clock) begin
    if (pause_input_n && byte_done) begin
      case (byte_q)
        sepc_pkg::BYTE_CMD: cmd_q  <= rx_byte;                  // Command
        sepc_pkg::BYTE_AHI: arg_q  <= rx_byte;                  // Address high or status
        sepc_pkg::BYTE_ALO: addr_q <= addr_full;                // Start address
        default: ;                                              // Data bytes
      endcase
    end
  end

  // Read pointer advances one byte per output byte and wraps at the top
  always_ff @(posedge shift_clock) begin
    if (pause_input_n && byte_done) begin
      if (byte_q == sepc_pkg::BYTE_ALO) begin
        rptr_q <= addr_full + ADDR_W'(1);
      end else if (byte_q >= sepc_pkg::BYTE_DATA && cmd_q == sepc_pkg::CMD_READ) begin
        rptr_q <= rptr_q + ADDR_W'(1);
      end
    end
  end

  // Page buffer bookkeeping; blocked while a cycle runs so its data stay intact
  always_ff @(posedge shift_clock) begin
    if (pause_input_n && fresh_q) begin
      wofs_q <= '0;
      mask_q <= '0;
    end else if (pb_we) begin
      wofs_q           <= wofs_q + PAGE_W'(1);
      mask_q[pb_waddr] <= 1'b1;
    end
  end

  // Status word into the link domain; bits change slowly, each synced alone
  always_ff @(posedge shift_clock) begin
    stat_s1_q <= status_w;
    stat_s2_q <= stat_s1_q;
  end

  // Output bit and phase; cleared at once by deselect
  always_ff @(negedge shift_clock or posedge device_select_n) begin
    if (device_select_n) begin
      so_q    <= 1'b0;
      drive_q <= 1'b0;
    end else if (!fresh_q && pause_input_n) begin
      if (load_rd) begin
        so_q    <= ar_rdata[7];
        drive_q <= 1'b1;
      end else if (load_st) begin
        so_q    <= stat_s2_q[7];
        drive_q <= 1'b1;
      end else if (drive_q) begin
        so_q    <= osr_q[6];
      end
    end
  end

  // Remaining output bits, no reset needed since drive_q guards them
  always_ff @(negedge shift_clock) begin
    if (!fresh_q && pause_input_n) begin
      if (load_rd) begin
        osr_q <= ar_rdata[6:0];
      end else if (load_st) begin
        osr_q <= stat_s2_q[6:0];
      end else begin
        osr_q <= {osr_q[5:0], 1'b0};
      end
    end
  end

  // Pause and deselect float the output with no clock edge needed
  assign serial_out    = so_q;
  assign serial_out_oe = drive_q & pause_input_n & ~device_select_n;

  // ==========================================================================
  // Page buffer (link writes, engine reads) and array (engine writes, link reads)
  sepc_ram #(.W(8), .AW(PAGE_W)) u_page (
    .wr_clk    (shift_clock),
    .wr_en     (pb_we),
    .wr_addr   (pb_waddr),
    .wr_data   (rx_byte),
    .rd_clk    (clock),
    .rd_en     (1'b1),
    .rd_addr   (idx_q[PAGE_W-1:0]),
    .rd_data_q (pb_rdata)
  );

  sepc_ram #(.W(8), .AW(ADDR_W)) u_array (
    .wr_clk    (clock),
    .wr_en     (ar_we),
    .wr_addr   (ar_waddr),
    .wr_data   (pb_rdata),
    .rd_clk    (shift_clock),
    .rd_en     (pause_input_n),
    .rd_addr   (ar_raddr),
    .rd_data_q (ar_rdata)
  );

  // ==========================================================================
  // Pin synchronisers in the system domain
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
    end else begin
      cs_s1_q <= device_select_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      wp_s1_q <= protect_pin_n;
      wp_s2_q <= wp_s1_q;
    end
  end

  // Frame judgement; link fields are still because the shift clock has stopped
  assign commit   = cs_s2_q & ~cs_s3_q;
  // The frame marker is already set again by the deselect, so only the counts are judged;
  // a frame with no edges leaves the last counts, and repeating those is harmless
  assign whole    = (bit_q == 3'h0);                            // Ends on a byte boundary
  assign wren_ok  = commit && whole && byte_q == sepc_pkg::LEN_CTRL
                    && cmd_q == sepc_pkg::CMD_WREN;
  assign wrdi_ok  = commit && whole && byte_q == sepc_pkg::LEN_CTRL
                    && cmd_q == sepc_pkg::CMD_WRDI;
  assign write_ok = commit && whole && byte_q >= sepc_pkg::LEN_WRMIN
                    && cmd_q == sepc_pkg::CMD_WRITE && wel_q
                    && state_q == sepc_pkg::SEPC_IDLE;
  assign wrsr_ok  = commit && whole && byte_q == sepc_pkg::LEN_WRSR
                    && cmd_q == sepc_pkg::CMD_WRSR && wel_q
                    && state_q == sepc_pkg::SEPC_IDLE
                    && !(protect_pin_enable_bit_q && !wp_s2_q);
  // Commit lags the pin by the sync stages, so the end is pulled in to match
  assign done     = (state_q == sepc_pkg::SEPC_WAIT)
                    && (tmr_q == TWC_CYCLES - sepc_pkg::SYNC_LAG - 1);
  assign ar_waddr = {base_q[ADDR_W-1:PAGE_W], pidx_q};
  assign ar_we    = pv_q && mask_l_q[pidx_q] && !blk_prot(ar_waddr, bp_q);

  // Write engine; nothing but its own timer ends a cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= sepc_pkg::SEPC_IDLE;
    end else begin
      case (state_q)
        sepc_pkg::SEPC_IDLE: begin
          if (write_ok) begin
            state_q <= sepc_pkg::SEPC_COPY;
          end else if (wrsr_ok) begin
            state_q <= sepc_pkg::SEPC_WAIT;
          end
        end
        sepc_pkg::SEPC_COPY: begin
          if (idx_q == (PAGE_W+1)'(PAGES)) begin
            state_q <= sepc_pkg::SEPC_WAIT;
          end
        end
        sepc_pkg::SEPC_WAIT: begin
          if (done) begin
            state_q <= sepc_pkg::SEPC_IDLE;
          end
        end
        default: state_q <= sepc_pkg::SEPC_IDLE;
      endcase
    end
  end

  // Cycle timer, restarted at each commit
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_q <= '0;
    end else if (write_ok || wrsr_ok || state_q == sepc_pkg::SEPC_IDLE) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + 32'h1;
    end
  end

  // Commit snapshot; protect pin is judged here only, later changes are moot
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mask_l_q  <= '0;
      base_q    <= '0;
      is_stat_q <= 1'b0;
      nstat_q   <= 8'h00;
    end else if (write_ok) begin
      mask_l_q  <= mask_q;
      base_q    <= addr_q;
      is_stat_q <= 1'b0;
    end else if (wrsr_ok) begin
      nstat_q   <= arg_q;
      is_stat_q <= 1'b1;
    end
  end

  // Page copy pipeline, one slot per cycle with one cycle of read latency
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      idx_q  <= '0;
      pidx_q <= '0;
      pv_q   <= 1'b0;
    end else begin
      pv_q   <= (state_q == sepc_pkg::SEPC_COPY) && (idx_q < (PAGE_W+1)'(PAGES));
      pidx_q <= idx_q[PAGE_W-1:0];
      if (write_ok) begin
        idx_q <= '0;
      end else if (state_q == sepc_pkg::SEPC_COPY && idx_q < (PAGE_W+1)'(PAGES)) begin
        idx_q <= idx_q + (PAGE_W+1)'(1);
      end
    end
  end

  // Status bits; a latch set in the same cycle as a cycle end wins
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wel_q  <= sepc_pkg::WEL_RST;
      wip_q  <= 1'b0;
      protect_pin_enable_bit_q <= sepc_pkg::PROTECT_PIN_ENABLE_BIT_RST;
      bp_q   <= sepc_pkg::BP_RST;
    end else begin
      if (write_ok || wrsr_ok) begin
        wip_q <= 1'b1;
      end else if (done) begin
        wip_q <= 1'b0;
      end
      if (wren_ok) begin
        wel_q <= 1'b1;
      end else if (wrdi_ok || done) begin
        wel_q <= 1'b0;
      end
      if (done && is_stat_q) begin
        protect_pin_enable_bit_q <= nstat_q[sepc_pkg::ST_PROTECT_PIN_ENABLE_BIT];
        bp_q   <= nstat_q[sepc_pkg::ST_BP1:sepc_pkg::ST_BP0];
      end
    end
  end

  assign status_w = {protect_pin_enable_bit_q, 3'b000, bp_q, wel_q, wip_q};
  assign write_busy = wip_q;

  // Standby only once deselected and no cycle is left running
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      standby_q <= 1'b1;
    end else begin
      standby_q <= cs_s2_q && (state_q == sepc_pkg::SEPC_IDLE) && !commit;
    end
  end

  assign standby = standby_q;

endmodule : sepc_core

`default_nettype wire

// file: sepc_host.sv
// Host model for the serial memory link pins
`timescale 1ns/1ps
`default_nettype none
module sepc_host (
  input  wire logic clock,
  input  wire logic serial_out,
  input  wire logic serial_out_oe,
  output var  logic device_select_n = 1'b1,
  output var  logic shift_clock     = 1'b0,
  output var  logic serial_in       = 1'b0,
  output var  logic pause_input_n   = 1'b1
);
  // Half link period of 16 system clocks (80 ns)
  task automatic half();
    repeat (16) @(negedge clock);
  endtask : half
  // Shift n bits MSB first, gathering the returned bits at each rise
  task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    device_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = tx[i];
      half();
      shift_clock = 1'b1;
      rx = {rx[30:0], serial_out_oe ? serial_out : ~serial_out}; // Undriven line reads wrong
      half();
      shift_clock = 1'b0;
    end
  endtask : frame
  // Released data line shows the inverse of its last bit
  task automatic close();
    device_select_n = 1'b1;
    serial_in = ~serial_in;
    repeat (4) half();
  endtask : close
  // Power-up select pulse with the clock still, so the link side starts clean
  task automatic wake();
    device_select_n = 1'b0;
    half();
    device_select_n = 1'b1;
    repeat (4) half();
  endtask : wake
  // Pause with the clock low, wiggle the ignored pins, then resume
  task automatic hold(output logic [1:0] oe);
    half(); // Keep the pause off the shift clock fall just made
    pause_input_n = 1'b0;
    half();
    oe[1] = serial_out_oe;
    repeat (4) begin
      shift_clock = ~shift_clock;
      serial_in = ~serial_in;
      half();
    end
    pause_input_n = 1'b1;
    half();
    oe[0] = serial_out_oe;
  endtask : hold
endmodule : sepc_host
`default_nettype wire

// file: sepc_core_assertions.sv
// Checker for the serial memory pin control block
`timescale 1ns/1ps
`default_nettype none
module sepc_core_assertions #(
  parameter int unsigned TWC_CYCLES = 200 // Write cycle length
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic shift_clock,
  input wire logic device_select_n,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic pause_input_n,
  input wire logic write_busy,
  input wire logic standby
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Length of the running write cycle
  int unsigned busy_cnt_q;
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst) busy_cnt_q <= '0;
    else busy_cnt_q <= write_busy ? busy_cnt_q + 1 : '0;
  a_desel_float: assert property (device_select_n |-> !serial_out_oe) else $error("driven deselected");
  a_pause_float: assert property (!pause_input_n |-> !serial_out_oe) else $error("driven paused");
  a_busy_awake: assert property (write_busy |-> !standby) else $error("standby while busy");
  a_busy_bound: assert property (busy_cnt_q < TWC_CYCLES) else $error("write cycle too long");
  a_idle_standby: assert property (device_select_n [*4] ##0 $fell(write_busy) |=> standby)
    else $error("no standby after cycle");
  a_select_wakes: assert property (!device_select_n [*5] |-> !standby) else $error("standby selected");
  a_commit_rise: assert property ($rose(write_busy) |-> device_select_n) else $error("commit selected");
  a_out_fall: assert property ($changed(serial_out) && !device_select_n && !$past(device_select_n)
    |-> !shift_clock) else $error("output moved off fall");
endmodule : sepc_core_assertions
bind sepc_core sepc_core_assertions #(.TWC_CYCLES(TWC_CYCLES)) i_sepc_core_assertions (.clock(clock),
  .sys_rst(sys_rst), .shift_clock(shift_clock), .device_select_n(device_select_n), .serial_out(serial_out),
  .serial_out_oe(serial_out_oe), .pause_input_n(pause_input_n), .write_busy(write_busy), .standby(standby));
`default_nettype wire

// file: tb.sv
// Self-checking bench for the serial memory pin control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0, sys_rst = 1'b1, protect_pin_n = 1'b1;
  wire logic device_select_n, shift_clock, serial_in, pause_input_n, serial_out, serial_out_oe, write_busy, standby;
  int num_errors = 0, checks_done = 0;
  logic [31:0] rx;
  logic [1:0] oe;
  initial forever #2.5 clock = ~clock;
  sepc_core #(.TWC_CYCLES(200)) i_sepc_core (.clock(clock), .sys_rst(sys_rst), .shift_clock(shift_clock),
    .device_select_n(device_select_n), .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .protect_pin_n(protect_pin_n), .pause_input_n(pause_input_n), .write_busy(write_busy), .standby(standby));
  sepc_host i_sepc_host (.clock(clock), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .device_select_n(device_select_n), .shift_clock(shift_clock), .serial_in(serial_in), .pause_input_n(pause_input_n));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cmd(input int n, input logic [31:0] tx);
    i_sepc_host.frame(n, tx, rx);
    i_sepc_host.close();
  endtask : cmd
  // Cycle must be running, end in bounded time, then fall back to standby
  task automatic wait_idle();
    chk("busy", 8'h01, {7'h0, write_busy});
    for (int n = 0; n < 400 && write_busy !== 1'b0; n++) @(negedge clock);
    repeat (2) @(negedge clock);
    chk("standby", 8'h01, {7'h0, standby});
  endtask : wait_idle
  task automatic rdsr(input logic [7:0] exp);
    cmd(16, {16'h0, sepc_pkg::CMD_RDSR, 8'h00});
    chk("status", exp, rx[7:0]);
  endtask : rdsr
  // Page write then read back across a pause
  task automatic test_write_read();
    cmd(8, {24'h0, sepc_pkg::CMD_WREN});
    cmd(32, {sepc_pkg::CMD_WRITE, 16'h0040, 8'ha5});
    wait_idle();
    // Stop in mid-byte so the pause must keep the output position
    i_sepc_host.frame(28, {4'h0, sepc_pkg::CMD_READ, 16'h0040, 4'h0}, rx);
    chk("read_hi", 8'h0a, {4'h0, rx[3:0]});
    i_sepc_host.hold(oe);
    chk("pause_oe", 8'h01, {6'h0, oe});
    i_sepc_host.frame(4, 32'h0, rx);
    chk("read_lo", 8'h05, {4'h0, rx[3:0]});
    i_sepc_host.close();
    chk("idle_oe", 8'h00, {7'h0, serial_out_oe});
  endtask : test_write_read
  // Cut write frame must not start a cycle
  task automatic test_bad_rise();
    cmd(8, {24'h0, sepc_pkg::CMD_WREN});
    cmd(28, {4'h0, sepc_pkg::CMD_WRITE, 16'h0080, 4'h1});
    chk("cut_busy", 8'h00, {7'h0, write_busy});
  endtask : test_bad_rise
  // Protect pin against the enable bit
  task automatic test_protect();
    protect_pin_n = 1'b0;
    cmd(8, {24'h0, sepc_pkg::CMD_WREN});
    cmd(16, {16'h0, sepc_pkg::CMD_WRSR, 8'h80});
    wait_idle();
    rdsr(8'h80);
    cmd(8, {24'h0, sepc_pkg::CMD_WREN});
    cmd(16, {16'h0, sepc_pkg::CMD_WRSR, 8'h00});
    rdsr(8'h82);
    protect_pin_n = 1'b1;
    cmd(16, {16'h0, sepc_pkg::CMD_WRSR, 8'h00});
    protect_pin_n = 1'b0;
    wait_idle();
    rdsr(8'h00);
  endtask : test_protect
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (16) @(negedge clock);
    sys_rst = 1'b0;
    repeat (8) @(negedge clock);
    i_sepc_host.wake();
    test_write_read();
    test_bad_rise();
    test_protect();
    give_verdict();
  end
  // Watchdog well past the expected run
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
